// [hdl/itfm_mux.sv]
// Module: input terminal function mux with APB settings registers
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Five terminals, each with its own select; defaults 60,61,0,1,2.
// - Decoder: 3 second,5 jog,14 PID,24 stop,62 reset,9999 none.
// - One code on several terminals drives the same function, except forward/reverse.
// - Speed priority: jog over all; multi-speed over PID only while remote param is 0.
// - Without an enable terminal, output stop also drives enable.
// - Mode 7 without interlock terminal: output stop drives interlock.
// - Remote param nonzero: low/mid/high become clear/decel/accel.
// - Multi-speed and remote setting share the same terminals.
// - Code 8 is the extended speed input, giving up to 15 speeds.
// - Thermal relay reads asserted when the contact opens.
// - V/f switch asserts V/f control and second function together.
// - No V/f change while running; only second function then.
// - Analogue-4 select marks analogue terminal 2 voltage invalid.
// - Codes 16, 65, 66 select external, panel, network operation.
// - Enable and output stop act within 2 ms.
// - Other functions act within 20 ms.
// - Select writes accepted only while extended display equals 0.
module itfm_mux #(
   parameter int TICK_CYC = itfm_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Terminals and drive state
   input  wire logic [4:0]  i_term,
   input  wire logic        i_running,
   // Decoded functions
   output logic             o_forward_run,
   output logic             o_reverse_run,
   output logic [3:0]       o_speed_sel,
   output logic             o_jog_active,
   output logic             o_pid_active,
   output logic             o_remote_clear,
   output logic             o_remote_decel,
   output logic             o_remote_accel,
   output logic             o_second_func,
   output logic             o_ain2_invalid,
   output logic             o_thermal_trip,
   output logic             o_conv_enable,
   output logic             o_ext_interlock,
   output logic             o_sel_external,
   output logic             o_sel_panel,
   output logic             o_sel_network,
   output logic             o_cmd_source,
   output logic             o_vf_control,
   output logic             o_output_stop,
   output logic             o_self_hold,
   output logic             o_traverse,
   output logic             o_drive_reset
);
   // ------------------------------------------------------------
   // Settings registers
   // ------------------------------------------------------------
   logic [15:0] sel_r [5];
   logic [15:0] remote_r;
   logic [7:0]  mode_r;
   logic [7:0]  extdisp_r;
   logic        vf_r;
   logic        apb_acc;
   logic        apb_wr;
   logic        mapped;

   assign apb_acc = i_psel && i_penable;
   assign apb_wr  = apb_acc && i_pwrite;
   assign mapped  = (i_paddr <= itfm_pkg::ADDR_TERM) && (i_paddr[1:0] == 2'b00);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_r[0] <= itfm_pkg::RST_SEL0;
         sel_r[1] <= itfm_pkg::RST_SEL1;
         sel_r[2] <= itfm_pkg::RST_SEL2;
         sel_r[3] <= itfm_pkg::RST_SEL3;
         sel_r[4] <= itfm_pkg::RST_SEL4;
      end else if (apb_wr && extdisp_r == 8'h00) begin
         case (i_paddr)
            itfm_pkg::ADDR_SEL0: sel_r[0] <= i_pwdata[15:0];
            itfm_pkg::ADDR_SEL1: sel_r[1] <= i_pwdata[15:0];
            itfm_pkg::ADDR_SEL2: sel_r[2] <= i_pwdata[15:0];
            itfm_pkg::ADDR_SEL3: sel_r[3] <= i_pwdata[15:0];
            itfm_pkg::ADDR_SEL4: sel_r[4] <= i_pwdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         remote_r  <= 16'h0000;
         mode_r    <= 8'h00;
         extdisp_r <= 8'h00;
      end else if (apb_wr && i_paddr == itfm_pkg::ADDR_CFG) begin
         remote_r  <= i_pwdata[itfm_pkg::CFG_REMOTE_LSB +: 16];
         mode_r    <= i_pwdata[itfm_pkg::CFG_MODE_LSB +: 8];
         extdisp_r <= i_pwdata[itfm_pkg::CFG_EXTDISP_LSB +: 8];
      end
   end

   // ------------------------------------------------------------
   // Terminal synchroniser and settle filter
   // ------------------------------------------------------------
   logic [4:0]  term_m;
   logic [4:0]  term_s;
   logic [4:0]  term_slow;
   logic [15:0] tick_cnt;
   logic        tick;
   logic [2:0]  stab_cnt [5];

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         term_m <= 5'h00;
         term_s <= 5'h00;
      end else begin
         term_m <= i_term;
         term_s <= term_m;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick     <= 1'b0;
      end
   end

   // Slow path rejects contact bounce; fast path stays unfiltered
   for (genvar t = 0; t < 5; t++) begin : g_filt
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            stab_cnt[t]  <= 3'h0;
            term_slow[t] <= 1'b0;
         end else if (term_s[t] == term_slow[t]) begin
            stab_cnt[t] <= 3'h0;
         end else if (tick) begin
            if (stab_cnt[t] == 3'(itfm_pkg::SLOW_TICKS - 1)) begin
               term_slow[t] <= term_s[t];
               stab_cnt[t]  <= 3'h0;
            end else begin
               stab_cnt[t] <= stab_cnt[t] + 3'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Decode and merge
   // ------------------------------------------------------------
   function automatic logic any_fn(input logic [15:0] code,
                                   input logic [4:0]  lvl,
                                   input logic [15:0] s0,
                                   input logic [15:0] s1,
                                   input logic [15:0] s2,
                                   input logic [15:0] s3,
                                   input logic [15:0] s4);
      logic r;
      r = (s0 == code && lvl[0]) || (s1 == code && lvl[1]) ||
          (s2 == code && lvl[2]) || (s3 == code && lvl[3]) ||
          (s4 == code && lvl[4]);
      return r;
   endfunction

   function automatic logic has_fn(input logic [15:0] code,
                                   input logic [15:0] s0,
                                   input logic [15:0] s1,
                                   input logic [15:0] s2,
                                   input logic [15:0] s3,
                                   input logic [15:0] s4);
      logic r;
      r = s0 == code || s1 == code || s2 == code || s3 == code ||
          s4 == code;
      return r;
   endfunction

   logic f_low, f_mid, f_high, f_ext, f_jog, f_pid, f_stop, f_conv;
   logic f_ilock, f_vf, f_therm, has_conv, has_ilock, remote_on, jog_q;

   always_comb begin
      f_low   = any_fn(itfm_pkg::FC_LOW, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_mid   = any_fn(itfm_pkg::FC_MID, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_high  = any_fn(itfm_pkg::FC_HIGH, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_ext   = any_fn(itfm_pkg::FC_EXTSPD, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_jog   = any_fn(itfm_pkg::FC_JOG, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_pid   = any_fn(itfm_pkg::FC_PID, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_vf    = any_fn(itfm_pkg::FC_VF, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      // Contact open means trip, so a low terminal level asserts it
      f_therm = any_fn(itfm_pkg::FC_THERM, ~term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_stop  = any_fn(itfm_pkg::FC_STOP, term_s, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_conv  = any_fn(itfm_pkg::FC_CONVEN, term_s, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      f_ilock = any_fn(itfm_pkg::FC_ILOCK, term_slow, sel_r[0], sel_r[1],
                       sel_r[2], sel_r[3], sel_r[4]);
      has_conv  = has_fn(itfm_pkg::FC_CONVEN, sel_r[0], sel_r[1],
                         sel_r[2], sel_r[3], sel_r[4]);
      has_ilock = has_fn(itfm_pkg::FC_ILOCK, sel_r[0], sel_r[1],
                         sel_r[2], sel_r[3], sel_r[4]);
      remote_on = remote_r != 16'h0000;
      jog_q     = f_jog;
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_output_stop   <= 1'b0;
         o_conv_enable   <= 1'b0;
         o_ext_interlock <= 1'b0;
      end else begin
         o_output_stop   <= f_stop;
         o_conv_enable   <= has_conv ? f_conv : f_stop;
         o_ext_interlock <= (mode_r == itfm_pkg::MODE_ILOCK && !has_ilock)
                            ? f_stop : f_ilock;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_speed_sel    <= 4'h0;
         o_jog_active   <= 1'b0;
         o_pid_active   <= 1'b0;
         o_remote_clear <= 1'b0;
         o_remote_decel <= 1'b0;
         o_remote_accel <= 1'b0;
      end else begin
         // Same terminals feed both meanings, chosen by the remote param
         o_remote_clear <= remote_on && f_low;
         o_remote_decel <= remote_on && f_mid;
         o_remote_accel <= remote_on && f_high;
         o_jog_active   <= jog_q;
         if (jog_q) begin
            o_speed_sel  <= 4'h0;
            o_pid_active <= 1'b0;
         end else if (!remote_on && (f_low || f_mid || f_high || f_ext)) begin
            o_speed_sel  <= {f_ext, f_high, f_mid, f_low};
            o_pid_active <= 1'b0;
         end else begin
            o_speed_sel  <= remote_on ? {f_ext, 3'b000} : 4'h0;
            o_pid_active <= f_pid;
         end
      end
   end

   // V/f mode is latched only while stopped
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         vf_r <= 1'b0;
      end else if (!i_running) begin
         vf_r <= f_vf;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_forward_run  <= 1'b0;
         o_reverse_run  <= 1'b0;
         o_second_func  <= 1'b0;
         o_vf_control   <= 1'b0;
         o_ain2_invalid <= 1'b0;
         o_thermal_trip <= 1'b0;
         o_sel_external <= 1'b0;
         o_sel_panel    <= 1'b0;
         o_sel_network  <= 1'b0;
         o_cmd_source   <= 1'b0;
         o_self_hold    <= 1'b0;
         o_traverse     <= 1'b0;
         o_drive_reset  <= 1'b0;
      end else begin
         // Forward/reverse codes are honoured only on their own terminal
         o_forward_run  <= sel_r[0] == itfm_pkg::FC_FWD && term_slow[0];
         o_reverse_run  <= sel_r[1] == itfm_pkg::FC_REV && term_slow[1];
         o_second_func  <= f_vf || any_fn(itfm_pkg::FC_SECOND, term_slow,
                           sel_r[0], sel_r[1], sel_r[2], sel_r[3],
                           sel_r[4]);
         o_vf_control   <= vf_r;
         o_ain2_invalid <= any_fn(itfm_pkg::FC_AIN4, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_thermal_trip <= f_therm;
         o_sel_external <= any_fn(itfm_pkg::FC_PEXT, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_sel_panel    <= any_fn(itfm_pkg::FC_PNET, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_sel_network  <= any_fn(itfm_pkg::FC_ENET, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_cmd_source   <= any_fn(itfm_pkg::FC_CMDSRC, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_self_hold    <= any_fn(itfm_pkg::FC_SELFH, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_traverse     <= any_fn(itfm_pkg::FC_TRAV, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
         o_drive_reset  <= any_fn(itfm_pkg::FC_RESET, term_slow, sel_r[0],
                           sel_r[1], sel_r[2], sel_r[3], sel_r[4]);
      end
   end

   // ------------------------------------------------------------
   // APB read path, no wait states
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         o_pready  <= 1'b1;
         o_pslverr <= !mapped;
         o_prdata  <= 32'h0000_0000;
         if (!i_pwrite) begin
            case (i_paddr)
               itfm_pkg::ADDR_SEL0:   o_prdata <= {16'h0000, sel_r[0]};
               itfm_pkg::ADDR_SEL1:   o_prdata <= {16'h0000, sel_r[1]};
               itfm_pkg::ADDR_SEL2:   o_prdata <= {16'h0000, sel_r[2]};
               itfm_pkg::ADDR_SEL3:   o_prdata <= {16'h0000, sel_r[3]};
               itfm_pkg::ADDR_SEL4:   o_prdata <= {16'h0000, sel_r[4]};
               itfm_pkg::ADDR_CFG:    o_prdata <= {extdisp_r, mode_r,
                                                   remote_r};
               itfm_pkg::ADDR_STATUS: o_prdata <= {27'h0, term_s};
               itfm_pkg::ADDR_FUNC:   o_prdata <= {16'h0, o_speed_sel,
                                        o_jog_active, o_pid_active,
                                        o_second_func, o_vf_control,
                                        o_output_stop, o_conv_enable,
                                        o_ext_interlock, o_thermal_trip,
                                        o_sel_external, o_sel_panel,
                                        o_sel_network, o_ain2_invalid};
               itfm_pkg::ADDR_TERM:   o_prdata <= {27'h0, term_slow};
               default:               o_prdata <= 32'h0000_0000;
            endcase
         end
      end else begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_stop_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      !has_conv |=> o_conv_enable == $past(f_stop))
      else $error("enable does not follow output stop");
   chk_stop_ilock: assert property (@(posedge i_clk) disable iff (i_rst)
      (mode_r == itfm_pkg::MODE_ILOCK && !has_ilock)
      |=> o_ext_interlock == $past(f_stop))
      else $error("interlock does not follow output stop");
   chk_jog_priority: assert property (@(posedge i_clk) disable iff (i_rst)
      o_jog_active |-> o_speed_sel == 4'h0 && !o_pid_active)
      else $error("jog not highest priority");
   chk_pid_priority: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pid_active |-> o_speed_sel == 4'h0)
      else $error("pid active with multi-speed");
   chk_remote_share: assert property (@(posedge i_clk) disable iff (i_rst)
      o_remote_clear |-> $past(remote_on) && o_speed_sel[0] == 1'b0)
      else $error("remote clear without remote mode");
   chk_vf_second: assert property (@(posedge i_clk) disable iff (i_rst)
      o_vf_control |-> o_second_func || $past(!f_vf))
      else $error("vf without second function");
   chk_vf_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
      i_running && $past(i_running) |=> $stable(vf_r))
      else $error("vf changed while running");
   chk_write_lock: assert property (@(posedge i_clk) disable iff (i_rst)
      apb_wr && extdisp_r != 8'h00 && i_paddr == itfm_pkg::ADDR_SEL0
      |=> $stable(sel_r[0]))
      else $error("select written while locked");
   chk_fast_stop: assert property (@(posedge i_clk) disable iff (i_rst)
      sel_r[2] == itfm_pkg::FC_STOP && sel_r[2] == $past(sel_r[2])
      && term_s[2] |=> o_output_stop)
      else $error("output stop late");
   chk_thermal_open: assert property (@(posedge i_clk) disable iff (i_rst)
      sel_r[3] == itfm_pkg::FC_THERM && $stable(sel_r[3])
      && !term_slow[3] |=> o_thermal_trip)
      else $error("thermal not asserted on open");

   cov_jog: cover property (@(posedge i_clk) o_jog_active);
   cov_remote: cover property (@(posedge i_clk) o_remote_accel);
   cov_speed15: cover property (@(posedge i_clk) o_speed_sel == 4'hf);
   cov_locked: cover property (@(posedge i_clk)
      apb_wr && extdisp_r != 8'h00);
endmodule

// [hdl/itfm_pkg.sv]
// Package: register map, function codes and timing constants of the mux
package itfm_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_SEL0    = 12'h000;
   localparam logic [11:0] ADDR_SEL1    = 12'h004;
   localparam logic [11:0] ADDR_SEL2    = 12'h008;
   localparam logic [11:0] ADDR_SEL3    = 12'h00c;
   localparam logic [11:0] ADDR_SEL4    = 12'h010;
   localparam logic [11:0] ADDR_CFG     = 12'h014;
   localparam logic [11:0] ADDR_STATUS  = 12'h018;
   localparam logic [11:0] ADDR_FUNC    = 12'h01c;
   localparam logic [11:0] ADDR_TERM    = 12'h020;
   // CFG fields
   localparam int CFG_REMOTE_LSB  = 0;
   localparam int CFG_MODE_LSB    = 16;
   localparam int CFG_EXTDISP_LSB = 24;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_SEL0 = 16'h003c;
   localparam logic [15:0] RST_SEL1 = 16'h003d;
   localparam logic [15:0] RST_SEL2 = 16'h0000;
   localparam logic [15:0] RST_SEL3 = 16'h0001;
   localparam logic [15:0] RST_SEL4 = 16'h0002;
   // ------------------------------------------------------------
   // Function codes
   // ------------------------------------------------------------
   localparam logic [15:0] FC_LOW    = 16'h0000;
   localparam logic [15:0] FC_MID    = 16'h0001;
   localparam logic [15:0] FC_HIGH   = 16'h0002;
   localparam logic [15:0] FC_SECOND = 16'h0003;
   localparam logic [15:0] FC_AIN4   = 16'h0004;
   localparam logic [15:0] FC_JOG    = 16'h0005;
   localparam logic [15:0] FC_THERM  = 16'h0007;
   localparam logic [15:0] FC_EXTSPD = 16'h0008;
   localparam logic [15:0] FC_CONVEN = 16'h000a;
   localparam logic [15:0] FC_ILOCK  = 16'h000c;
   localparam logic [15:0] FC_PID    = 16'h000e;
   localparam logic [15:0] FC_PEXT   = 16'h0010;
   localparam logic [15:0] FC_VF     = 16'h0012;
   localparam logic [15:0] FC_STOP   = 16'h0018;
   localparam logic [15:0] FC_SELFH  = 16'h0019;
   localparam logic [15:0] FC_TRAV   = 16'h0025;
   localparam logic [15:0] FC_FWD    = 16'h003c;
   localparam logic [15:0] FC_REV    = 16'h003d;
   localparam logic [15:0] FC_RESET  = 16'h003e;
   localparam logic [15:0] FC_PNET   = 16'h0041;
   localparam logic [15:0] FC_ENET   = 16'h0042;
   localparam logic [15:0] FC_CMDSRC = 16'h0043;
   localparam logic [15:0] FC_NONE   = 16'h270f;
   localparam logic [7:0]  MODE_ILOCK = 8'h07;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ       = 100_000_000;
   localparam int FAST_RESP_US = 2000;
   localparam int SLOW_RESP_US = 20000;
   // Settle tick every 100 us; fast path uses no filter at all
   localparam int TICK_US      = 100;
   localparam int TICK_CYC     = (CLK_HZ / 1_000_000) * TICK_US;
   // Slow inputs need 4 stable ticks: worst case 4 ticks = 400 us
   localparam int SLOW_TICKS   = 4;
endpackage

// [verification/itfm_contacts.sv]
// Partner model: external contacts wired to the five input terminals
`timescale 1ns/100ps
module itfm_contacts (
   // Clock
   input  wire logic       i_clk,
   // Contact state requested by the bench, high = closed
   input  wire logic [4:0] i_close,
   // Terminal levels
   output logic      [4:0] o_term
);
   // Contacts take the requested state on each rising edge
   always_ff @(posedge i_clk) begin
      o_term <= i_close;
   end
endmodule

// [verification/itfm_mux_tb_top.sv]
// Testbench: APB settings, terminal decode, fallbacks and priorities
`timescale 1ns/100ps
module itfm_mux_tb_top;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, run = 0;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, rdv;
   logic pready, perr, erv, fwd, rev, jog, pid, rclr, rdec, racc, sec;
   logic ain2, therm, conv, ilck, sext, span, snet, vf, stp, drst;
   logic [3:0] spd;
   logic [4:0] close = 0, term;
   logic [15:0] codes [10];
   logic [8:0] fv;
   int err_count = 0, checks = 0, cyc = 0;
   always #5 clk = ~clk;
   assign fv = {drst, snet, span, sext, stp, pid, jog, sec, ain2};
   itfm_contacts cont_u (.i_clk(clk), .i_close(close), .o_term(term));
   itfm_mux #(.TICK_CYC(4)) dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
      .o_prdata(prd), .o_pready(pready), .o_pslverr(perr), .i_term(term),
      .i_running(run), .o_forward_run(fwd), .o_reverse_run(rev),
      .o_speed_sel(spd), .o_jog_active(jog), .o_pid_active(pid),
      .o_remote_clear(rclr), .o_remote_decel(rdec), .o_remote_accel(racc),
      .o_second_func(sec), .o_ain2_invalid(ain2), .o_thermal_trip(therm),
      .o_conv_enable(conv), .o_ext_interlock(ilck), .o_sel_external(sext),
      .o_sel_panel(span), .o_sel_network(snet), .o_cmd_source(),
      .o_vf_control(vf), .o_output_stop(stp), .o_self_hold(),
      .o_traverse(), .o_drive_reset(drst));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      rdv = prd;
      erv = perr;
      psel <= 0; pen <= 0;
      @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Slow inputs need 4 stable ticks of 4 cycles, plus sync stages
   task automatic settle(input logic [4:0] c);
      close <= c;
      repeat (40) @(posedge clk);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         results;
      end
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      codes = '{itfm_pkg::FC_AIN4, itfm_pkg::FC_SECOND, itfm_pkg::FC_JOG,
         itfm_pkg::FC_PID, itfm_pkg::FC_STOP, itfm_pkg::FC_PEXT,
         itfm_pkg::FC_PNET, itfm_pkg::FC_ENET, itfm_pkg::FC_RESET,
         itfm_pkg::FC_NONE};
      repeat (6) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(0, 12'h000, 0); chk("sel0", 32'h3c, rdv);
      apb(0, 12'h004, 0); chk("sel1", 32'h3d, rdv);
      apb(0, 12'h010, 0); chk("sel4", 32'h2, rdv);
      apb(0, 12'h024, 0); chk("unmapped", 1, erv);
      settle(5'b00001); chk("forward", 1, fwd);
      settle(5'b11100); chk("speed", 4'h7, spd);
      apb(1, itfm_pkg::ADDR_CFG, 32'h1); settle(5'b11100);
      chk("remote", 3'h7, {rclr, rdec, racc});
      chk("remote speed", 0, spd);
      apb(1, itfm_pkg::ADDR_CFG, 32'h0100_0000);
      apb(1, itfm_pkg::ADDR_SEL2, 32'h5); apb(0, itfm_pkg::ADDR_SEL2, 0);
      chk("locked", 0, rdv);
      apb(1, itfm_pkg::ADDR_CFG, 0); settle(0);
      for (int i = 0; i < 10; i++) begin
         apb(1, itfm_pkg::ADDR_SEL2, {16'h0, codes[i]});
         settle(5'b00100);
         chk("decode", (i < 9) ? (9'h1 << i) : 9'h0, fv);
         settle(0);
      end
      apb(1, itfm_pkg::ADDR_SEL2, {16'h0, itfm_pkg::FC_VF});
      settle(5'b00100); chk("vf idle", 2'h3, {vf, sec}); settle(0);
      run <= 1; settle(5'b00100); chk("vf run", 2'h1, {vf, sec});
      run <= 0; settle(0);
      apb(1, itfm_pkg::ADDR_SEL2, {16'h0, itfm_pkg::FC_STOP});
      apb(1, itfm_pkg::ADDR_CFG, 32'h0007_0000);
      close <= 5'b00100;
      repeat (5) @(posedge clk);
      #1 chk("stop fast", 3'h7, {stp, conv, ilck});
      apb(1, itfm_pkg::ADDR_CFG, 0);
      apb(1, itfm_pkg::ADDR_SEL3, {16'h0, itfm_pkg::FC_STOP});
      settle(5'b01000); chk("shared stop", 1, stp);
      apb(1, itfm_pkg::ADDR_SEL2, {16'h0, itfm_pkg::FC_PID});
      apb(1, itfm_pkg::ADDR_SEL3, {16'h0, itfm_pkg::FC_JOG});
      settle(5'b11100); chk("jog first", 2'h2, {jog, pid});
      settle(5'b10100); chk("speed over pid", 5'h4, {pid, spd});
      apb(1, itfm_pkg::ADDR_SEL2, {16'h0, itfm_pkg::FC_THERM});
      settle(0); chk("relay open", 1, therm);
      settle(5'b00100); chk("relay closed", 0, therm);
      apb(1, itfm_pkg::ADDR_SEL2, {16'h0, itfm_pkg::FC_EXTSPD});
      settle(5'b10100); chk("ext speed", 4'hc, spd);
      results;
   end
endmodule
